//--- logic/regulator_transition_control_reg.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [RQ1] Under software control, writing 1 to the trigger bit starts a move to the new target.
// [RQ2] The trigger is bit 7 and writes to it are ignored while hardware control is selected.
// [RQ3] The trigger bit clears itself when the move it started has finished.
// [RQ4] With bit 6 clear and the regulator disabled the output pull-down stays off.
// [RQ5] With bit 6 set and the regulator disabled the output pull-down is turned on.
// [RQ6] The status flag is read only; 1 means out of regulation or in current limit.
// [RQ7] Code 000 gives the slowest ramp, 0.15 mV/us; slewing applies to rising moves only.
// [RQ8] Slew code 110 gives the fastest rising ramp of 9.60 mV/us.
// [RQ9] Codes 001 to 101 give 0.30, 0.60, 1.20, 2.40 and 4.80 mV/us.
// [RQ10] The status flag sits in bit 5.
// [RQ11] Bits 4 and 3 read as zero and ignore writes.
module regulator_transition_control_reg
   import xfer_ctl_pkg::*;
#(
   parameter int unsigned LSB_UV        = LSB_UV_DFLT,
   parameter int unsigned SLOW_STEP_CYC = LSB_UV * CLK_MHZ / SLEW_RATE_UV_US[0]
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic [7:0]          reg_addr,
   input  wire logic                reg_wr_en,
   input  wire logic [REG_W-1:0]    reg_wr_data,
   input  wire logic                reg_rd_en,
   output logic [REG_W-1:0]         reg_rd_data,
   input  wire logic                hw_sw_select,
   input  wire logic                regulator_enable,
   input  wire logic                regulation_fault_flag,
   input  wire logic [CODE_W-1:0]   target_code,
   output logic [CODE_W-1:0]        dac_code,
   output logic                     ramp_active,
   output logic                     off_state_pulldown,
   output logic [SLEW_W-1:0]        slew_code
);
   // =====================================
   // elaboration check
   if (LSB_UV == 0) begin : g_bad_lsb
      $error("regulator_transition_control_reg: LSB_UV must be nonzero");
   end

   logic                go_ff;
   logic                pulldown_ff;
   logic [SLEW_W-1:0]   slew_ff;
   logic [REG_W-1:0]    rd_data_ff;
   logic                pd_out_ff;
   logic [CODE_W-1:0]   dac_ff;
   logic [CODE_W-1:0]   target_ff;
   xfer_state_t         state_ff;
   xfer_state_t         nxt_state;

   logic wr_hit;
   logic go_start;
   logic go_done;
   logic rising;
   logic step;

   // =====================================
   // write decode
   assign wr_hit   = reg_wr_en && (reg_addr == TRANSITION_CONTROL_ADDR);
   assign go_start = wr_hit && reg_wr_data[GO_BIT] && !hw_sw_select; // RQ1 RQ2
   assign rising   = (state_ff == ST_RAMP) && (dac_ff < target_ff);
   assign go_done  = (state_ff == ST_RAMP) && (dac_ff == target_ff);

   // =====================================
   // trigger bit
   // a fresh start in the finishing cycle wins so the new move is not lost
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         go_ff <= GO_RST;
      end else if (go_start) begin
         go_ff <= 1'b1; // RQ1
      end else if (go_done) begin
         go_ff <= 1'b0; // RQ3
      end
   end

   // =====================================
   // plain control fields
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulldown_ff <= PULLDOWN_RST;
         slew_ff     <= SLEW_RST;
      end else if (wr_hit) begin
         pulldown_ff <= reg_wr_data[PULLDOWN_BIT];
         slew_ff     <= reg_wr_data[SLEW_HI_BIT:SLEW_LO_BIT];
      end
   end

   // =====================================
   // transition sequencer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (go_start) begin
               nxt_state = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (go_done && !go_start) begin
               nxt_state = ST_IDLE; // RQ3
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         target_ff <= '0;
      end else if (go_start) begin
         target_ff <= target_code; // RQ1
      end
   end

   // falling moves are not slewed; they land on the target in one cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dac_ff <= '0;
      end else if (state_ff == ST_RAMP && !go_start) begin
         if (dac_ff > target_ff) begin
            dac_ff <= target_ff; // RQ7
         end else if (rising && step) begin
            dac_ff <= dac_ff + 1'b1; // RQ7
         end
      end
   end

   slew_step_gen #(
      .SLOW_STEP_CYC (SLOW_STEP_CYC)
   ) u_step (
      .clk       (clk),
      .rst_n     (rst_n),
      .restart   (go_start),
      .run       (rising),
      .slew_code (slew_ff),
      .step      (step)
   );

   // =====================================
   // off-state discharge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pd_out_ff <= 1'b0;
      end else begin
         pd_out_ff <= pulldown_ff && !regulator_enable; // RQ4 RQ5
      end
   end

   // =====================================
   // read path, one cycle latency
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data_ff <= '0;
      end else if (reg_rd_en) begin
         if (reg_addr == TRANSITION_CONTROL_ADDR) begin
            rd_data_ff                            <= '0; // RQ11
            rd_data_ff[GO_BIT]                    <= go_ff;
            rd_data_ff[PULLDOWN_BIT]              <= pulldown_ff;
            rd_data_ff[FAULT_BIT]                 <= regulation_fault_flag; // RQ6 RQ10
            rd_data_ff[SLEW_HI_BIT:SLEW_LO_BIT]   <= slew_ff;
         end else begin
            rd_data_ff <= '0;
         end
      end
   end

   assign reg_rd_data        = rd_data_ff;
   assign dac_code           = dac_ff;
   assign ramp_active        = go_ff;
   assign off_state_pulldown = pd_out_ff;
   assign slew_code          = slew_ff;
endmodule
`default_nettype wire

//--- inc/xfer_ctl_pkg.sv
`default_nettype none
package xfer_ctl_pkg;
   // =====================================
   // register map
   localparam logic [7:0] TRANSITION_CONTROL_ADDR = 8'h03;
   localparam int         REG_W                   = 8;

   // =====================================
   // field positions
   localparam int GO_BIT       = 7;
   localparam int PULLDOWN_BIT = 6;
   localparam int FAULT_BIT    = 5;
   localparam int RSV_HI_BIT   = 4;
   localparam int RSV_LO_BIT   = 3;
   localparam int SLEW_HI_BIT  = 2;
   localparam int SLEW_LO_BIT  = 0;
   localparam int SLEW_W       = SLEW_HI_BIT - SLEW_LO_BIT + 1;

   // =====================================
   // reset values
   localparam logic             GO_RST       = 1'b0;
   localparam logic             PULLDOWN_RST = 1'b1;
   localparam logic [SLEW_W-1:0] SLEW_RST    = 3'h0;

   // =====================================
   // slew codes, rising transitions only
   localparam logic [SLEW_W-1:0] SLEW_SLOWEST = 3'h0;
   localparam logic [SLEW_W-1:0] SLEW_FASTEST = 3'h6;
   // rates in uV/us; each code doubles the previous one
   localparam int unsigned SLEW_RATE_UV_US [7] = '{150, 300, 600, 1200, 2400, 4800, 9600};

   // =====================================
   // timing
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned CODE_W       = 6;
   localparam int unsigned PERIOD_W     = 16;
   localparam int unsigned LSB_UV_DFLT  = 12500;

   typedef enum logic {ST_IDLE, ST_RAMP} xfer_state_t;
endpackage
`default_nettype wire

//--- logic/slew_step_gen.sv
`timescale 1ns/10ps
`default_nettype none
module slew_step_gen
   import xfer_ctl_pkg::*;
#(
   parameter int unsigned SLOW_STEP_CYC = 8333
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                restart,
   input  wire logic                run,
   input  wire logic [SLEW_W-1:0]   slew_code,
   output logic                     step
);
   // =====================================
   // elaboration check
   if (SLOW_STEP_CYC >= (1 << PERIOD_W) || (SLOW_STEP_CYC >> SLEW_FASTEST) < 1) begin : g_bad
      $error("slew_step_gen: SLOW_STEP_CYC out of range");
   end

   localparam logic [PERIOD_W-1:0] SLOW_CYC = PERIOD_W'(SLOW_STEP_CYC);

   logic [PERIOD_W-1:0] cnt_ff;
   logic [PERIOD_W-1:0] period;
   logic [SLEW_W-1:0]   eff_code;

   // =====================================
   // period per code
   // code 111 has no defined rate; it is held at the fastest one
   always_comb begin
      eff_code = (slew_code > SLEW_FASTEST) ? SLEW_FASTEST : slew_code;
      period   = SLOW_CYC >> eff_code; // RQ7 RQ8 RQ9
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (restart || !run) begin
         cnt_ff <= '0;
      end else if (cnt_ff >= period - 1'b1) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // a code change mid-ramp takes effect at once, the counter is compared not reloaded
   assign step = run && !restart && (cnt_ff >= period - 1'b1);
endmodule
`default_nettype wire

//--- tb/rtc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_assertions
   import xfer_ctl_pkg::*;
#(
   parameter int unsigned SLOW_STEP_CYC = 64
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [7:0]        reg_addr,
   input wire logic              reg_wr_en,
   input wire logic [REG_W-1:0]  reg_wr_data,
   input wire logic              reg_rd_en,
   input wire logic [REG_W-1:0]  reg_rd_data,
   input wire logic              hw_sw_select,
   input wire logic              regulator_enable,
   input wire logic              regulation_fault_flag,
   input wire logic [CODE_W-1:0] target_code,
   input wire logic [CODE_W-1:0] dac_code,
   input wire logic              ramp_active,
   input wire logic              off_state_pulldown,
   input wire logic [SLEW_W-1:0] slew_code
);
   // ==========
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic wr = reg_wr_en && reg_addr == TRANSITION_CONTROL_ADDR;
   wire logic rd = reg_rd_en && reg_addr == TRANSITION_CONTROL_ADDR;
   // pull-down follows the stored bit one edge after it lands
   sequence s_pd(v);
      wr && reg_wr_data[PULLDOWN_BIT] == v && !regulator_enable ##1 !wr && !regulator_enable;
   endsequence
   a_go_start: assert property (wr && reg_wr_data[GO_BIT] && !hw_sw_select |=> ramp_active)
      else $error("trigger write did not start a move");
   a_hw_no_go: assert property (wr && hw_sw_select && !ramp_active |=> !ramp_active)
      else $error("trigger acted under hardware control");
   a_idle_hold: assert property (!ramp_active |=> $stable(dac_code))
      else $error("setpoint moved while idle");
   a_pd_off: assert property (s_pd(1'b0) |=> !off_state_pulldown)
      else $error("pull-down on with bit clear");
   a_pd_on: assert property (s_pd(1'b1) |=> off_state_pulldown)
      else $error("pull-down off with bit set");
   a_fault_rd: assert property (rd |=>
      reg_rd_data[FAULT_BIT] == $past(regulation_fault_flag))
      else $error("status bit wrong on read");
   a_rsvd_zero: assert property (rd |=> reg_rd_data[RSV_HI_BIT:RSV_LO_BIT] == 2'h0)
      else $error("reserved bits not zero");
   a_slew_rd: assert property (rd && !reg_wr_en |=>
      reg_rd_data[SLEW_HI_BIT:0] == $past(slew_code))
      else $error("slew field wrong on read");
   a_rise_step: assert property (ramp_active && dac_code > $past(dac_code)
      |-> dac_code == CODE_W'($past(dac_code) + 1))
      else $error("rising move skipped a step");
endmodule
bind regulator_transition_control_reg rtc_assertions #(.SLOW_STEP_CYC(SLOW_STEP_CYC)) u_chk (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
   .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
   .hw_sw_select(hw_sw_select), .regulator_enable(regulator_enable),
   .regulation_fault_flag(regulation_fault_flag), .target_code(target_code),
   .dac_code(dac_code), .ramp_active(ramp_active),
   .off_state_pulldown(off_state_pulldown), .slew_code(slew_code));
`default_nettype wire

//--- tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input  wire logic       clk,
   output logic [7:0]      reg_addr,
   output logic            reg_wr_en,
   output logic [7:0]      reg_wr_data,
   output logic            reg_rd_en
);
   initial begin
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_wr_data = 8'h00;
      reg_rd_en = 1'b0;
   end
   // one-cycle strobe; released lines show the inverse, not the old value
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = w;
      reg_rd_en = !w;
      @(negedge clk);
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      reg_wr_data = ~d;
   endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import xfer_ctl_pkg::*;
   localparam int unsigned SLOW = 64;
   logic clk, rst_n, hw_sw_select, regulator_enable, regulation_fault_flag;
   logic ramp_active, off_state_pulldown, reg_wr_en, reg_rd_en;
   logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
   logic [5:0] target_code, dac_code;
   logic [2:0] slew_code;
   logic [7:0] exp_q[$];
   logic rd_d = 1'b0;
   int err_count = 0;
   int cmp_count = 0;
   always #5 clk = ~clk;
   host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en));
   regulator_transition_control_reg #(.SLOW_STEP_CYC(SLOW)) u_regulator_transition_control_reg (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
      .hw_sw_select(hw_sw_select), .regulator_enable(regulator_enable),
      .regulation_fault_flag(regulation_fault_flag), .target_code(target_code),
      .dac_code(dac_code), .ramp_active(ramp_active),
      .off_state_pulldown(off_state_pulldown), .slew_code(slew_code));
   // ==========
   // tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      exp_q.push_back(want);
      host.xfer(1'b0, a, 8'h00);
   endtask
   // cycles from trigger edge to completion
   task automatic ramp(input logic [5:0] t, input logic [2:0] c, input int want);
      int n;
      n = 0;
      target_code = t;
      host.xfer(1'b1, TRANSITION_CONTROL_ADDR, {5'h10, c});
      while (ramp_active === 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      chk(16'(n), 16'(want));
      chk(16'(dac_code), 16'(t));
      if (n >= 1000) end_sim();
   endtask
   // read data lands one edge after the strobe
   always @(posedge clk) rd_d <= reg_rd_en;
   always @(negedge clk) if (rd_d) chk(16'(reg_rd_data), 16'(exp_q.pop_front()));
   // ==========
   // main sequence
   initial begin
      logic [5:0] t;
      logic [2:0] s;
      {clk, rst_n, hw_sw_select, regulator_enable, regulation_fault_flag} = '0;
      target_code = '0;
      void'($urandom(4561));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      regulation_fault_flag = 1'($urandom);
      rd(TRANSITION_CONTROL_ADDR, {2'b01, regulation_fault_flag, 5'h00});
      hw_sw_select = 1'b1;
      s = 3'($urandom_range(6, 0));
      host.xfer(1'b1, TRANSITION_CONTROL_ADDR, {5'h1B, s});
      chk(16'(ramp_active), 16'h0000);
      chk(16'(slew_code), 16'(s));
      rd(TRANSITION_CONTROL_ADDR, {2'b01, regulation_fault_flag, 2'b00, s});
      rd(8'h04, 8'h00);
      $display("test register access done");
      hw_sw_select = 1'b0;
      host.xfer(1'b1, TRANSITION_CONTROL_ADDR, 8'h00);
      repeat (2) @(negedge clk);
      chk(16'(off_state_pulldown), 16'h0000);
      host.xfer(1'b1, TRANSITION_CONTROL_ADDR, 8'h40);
      repeat (2) @(negedge clk);
      chk(16'(off_state_pulldown), 16'h0001);
      regulator_enable = 1'b1;
      repeat (2) @(negedge clk);
      chk(16'(off_state_pulldown), 16'h0000);
      $display("test pull-down done");
      // rise from zero, then fall back; an equal target would finish one edge early
      for (int c = 0; c < 8; c++) begin
         t = 6'($urandom_range(3, 1));
         // code 111 has no rate of its own and runs at the fastest one
         ramp(t, 3'(c), int'(t) * int'(SLOW >> ((c > 6) ? 6 : c)) + 1);
         ramp(6'h00, 3'(c), 2);
      end
      $display("test slew codes done");
      end_sim();
   end
endmodule
`default_nettype wire
